// ### hdl/bsfr_device_end.sv
// network-side frame builder, one frame per request
// assumes the far end samples on the same clock
//
// Overview of operation
// - network side sends exactly three SYN first
// - sender toward network gives two+ SYN
// - one all-ones pad follows block check
// - leading SYN and pad excluded from frame length
// - frame opens with DLE then STX
// - receiver drops phase on bad start pair
// - data portion closes with DLE ETX
// - ETX ends only after odd DLE run
// - two characters after end are check
// - every data DLE is sent doubled; the code doubles info-byte DLEs only, a DLE control byte goes single
// - control marker DLEs are never doubled
// - receiver collapses DLE DLE to one DLE
// - DLE ETX ends transparent receive mode
// - DLE SYN time-fill discarded, not checked
// - block check directly follows end marker
// - check covers address, control, info and end ETX
// - end ETX checked, end DLE not
// - characters go lsb first
// - address 03 command, 01 response here
// - only information frames carry info bytes
`timescale 1ns/100ps
`default_nettype none
module bsfr_device_end (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // frame request
  input wire logic frameStart,
  input wire logic frameIsResponse,
  input wire logic [7:0] frameControl,
  output logic frameBusy,
  output logic frameDone,
  output logic [15:0] frameLength,
  // information bytes
  input wire logic [7:0] infoData,
  input wire logic infoLast,
  input wire logic infoValid,
  output logic infoReady,
  // serial line
  bsfr_link_if.device link
);
  import bsfr_pkg::*;

  typedef enum logic [3:0] {
    TX_IDLE, TX_SYN, TX_SDLE, TX_STX, TX_ADDR, TX_CTRL, TX_INFO, TX_STUFF,
    TX_FDLE, TX_FSYN, TX_EDLE, TX_ETX, TX_BCL, TX_BCH, TX_PAD
  } bsfr_tx_state_t;

  bsfr_tx_state_t stateReg;
  bsfr_tx_state_t stateNext;
  bsfr_tx_state_t pickState;
  logic [7:0] shiftReg;
  logic [2:0] bitCntReg;
  logic [1:0] synCntReg;
  logic [15:0] crcReg;
  logic [7:0] addrReg;
  logic [7:0] ctrlReg;
  logic infoFrameReg;
  logic lastReg;
  logic curDleReg;
  logic [15:0] lenCntReg;
  logic busyReg;
  logic doneReg;
  logic [15:0] lengthReg;
  logic lineReg;
  logic [7:0] charNext;
  logic [7:0] pickChar;
  logic pickPop;
  logic popSel;
  logic feedCrc;
  logic load;
  logic [FIFO_WIDTH-1:0] fifoOut;
  logic fifoValid;

  bsfr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inData({infoLast, infoData}),
    .inValid(infoValid),
    .inReady(infoReady),
    .outData(fifoOut),
    .outValid(fifoValid),
    .outReady(load && popSel)
  );

  // next char loads as the last bit goes out
  assign load = (stateReg == TX_IDLE) ? frameStart : (bitCntReg == 3'h7);

  // what follows a char that may precede info
  always_comb
  begin
    pickState = TX_EDLE;
    pickChar = CHAR_DLE;
    pickPop = 1'b0;
    if (infoFrameReg && !lastReg)
    begin
      if (fifoValid)
      begin
        pickState = TX_INFO;
        pickChar = fifoOut[7:0];
        pickPop = 1'b1;
      end
      else
      begin
        // underrun: time-fill keeps the frame alive
        pickState = TX_FDLE;
        pickChar = CHAR_DLE;
      end
    end
  end

  always_comb
  begin
    stateNext = stateReg;
    charNext = CHAR_PAD;
    popSel = 1'b0;
    feedCrc = 1'b0;
    case (stateReg)
      TX_IDLE:
      begin
        stateNext = TX_SYN;
        charNext = CHAR_SYN;
      end
      TX_SYN:
      begin
        if (synCntReg < TX_SYN_COUNT)
        begin
          charNext = CHAR_SYN;
        end
        else
        begin
          stateNext = TX_SDLE;
          charNext = CHAR_DLE;
        end
      end
      TX_SDLE:
      begin
        stateNext = TX_STX;
        charNext = CHAR_STX;
      end
      TX_STX:
      begin
        stateNext = TX_ADDR;
        charNext = addrReg;
        feedCrc = 1'b1;
      end
      TX_ADDR:
      begin
        stateNext = TX_CTRL;
        charNext = ctrlReg;
        feedCrc = 1'b1;
      end
      TX_CTRL, TX_STUFF, TX_FSYN:
      begin
        stateNext = pickState;
        charNext = pickChar;
        popSel = pickPop;
        feedCrc = pickPop;
      end
      TX_INFO:
      begin
        if (curDleReg)
        begin
          stateNext = TX_STUFF;
          charNext = CHAR_DLE;
        end
        else
        begin
          stateNext = pickState;
          charNext = pickChar;
          popSel = pickPop;
          feedCrc = pickPop;
        end
      end
      TX_FDLE:
      begin
        stateNext = TX_FSYN;
        charNext = CHAR_SYN;
      end
      TX_EDLE:
      begin
        stateNext = TX_ETX;
        charNext = CHAR_ETX;
        feedCrc = 1'b1;
      end
      TX_ETX:
      begin
        stateNext = TX_BCL;
        charNext = crcReg[7:0];
      end
      TX_BCL:
      begin
        stateNext = TX_BCH;
        charNext = crcReg[15:8];
      end
      TX_BCH:
      begin
        stateNext = TX_PAD;
        charNext = CHAR_PAD;
      end
      TX_PAD:
      begin
        stateNext = TX_IDLE;
      end
      default:
      begin
        stateNext = TX_IDLE;
      end
    endcase
  end

  // sequencing and serialiser
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= TX_IDLE;
      shiftReg <= 8'hFF;
      bitCntReg <= 3'h0;
      lineReg <= LINE_IDLE;
    end
    else if (load)
    begin
      stateReg <= stateNext;
      bitCntReg <= 3'h0;
      if (stateNext == TX_IDLE)
      begin
        lineReg <= LINE_IDLE;
        shiftReg <= 8'hFF;
      end
      else
      begin
        lineReg <= charNext[0];
        shiftReg <= {1'b1, charNext[7:1]};
      end
    end
    else if (stateReg != TX_IDLE)
    begin
      bitCntReg <= bitCntReg + 3'h1;
      lineReg <= shiftReg[0];
      shiftReg <= {1'b1, shiftReg[7:1]};
    end
  end

  // header fields, latched on request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrReg <= ADDR_NET_CMD;
      ctrlReg <= 8'h00;
      infoFrameReg <= 1'b0;
    end
    else if (stateReg == TX_IDLE && frameStart)
    begin
      addrReg <= frameIsResponse ? ADDR_NET_RSP : ADDR_NET_CMD;
      ctrlReg <= frameControl;
      infoFrameReg <= !frameControl[CTRL_KIND_BIT];
    end
  end

  // per-frame SYN count, last byte, DLE double, check
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synCntReg <= 2'h0;
      lastReg <= 1'b0;
      curDleReg <= 1'b0;
      crcReg <= BCW_INIT;
    end
    else if (load)
    begin
      if (stateReg == TX_IDLE)
      begin
        synCntReg <= 2'h1;
        lastReg <= 1'b0;
        crcReg <= BCW_INIT;
      end
      else if (stateNext == TX_SYN)
      begin
        synCntReg <= synCntReg + 2'h1;
      end
      if (popSel)
      begin
        lastReg <= fifoOut[8];
        curDleReg <= (fifoOut[7:0] == CHAR_DLE);
      end
      if (feedCrc)
      begin
        crcReg <= bsfrCrcByte(crcReg, charNext);
      end
    end
  end

  // length spans start marker to check word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lenCntReg <= 16'h0000;
      lengthReg <= 16'h0000;
      busyReg <= 1'b0;
      doneReg <= 1'b0;
    end
    else
    begin
      doneReg <= 1'b0;
      if (load && stateReg == TX_IDLE)
      begin
        lenCntReg <= 16'h0000;
        busyReg <= 1'b1;
      end
      else if (load && stateNext != TX_SYN && stateNext != TX_PAD && stateNext != TX_IDLE)
      begin
        lenCntReg <= lenCntReg + 16'h0001;
      end
      if (load && stateReg == TX_PAD)
      begin
        lengthReg <= lenCntReg;
        busyReg <= 1'b0;
        doneReg <= 1'b1;
      end
    end
  end

  assign frameBusy = busyReg;
  assign frameDone = doneReg;
  assign frameLength = lengthReg;
  assign link.lineBit = lineReg;
endmodule : bsfr_device_end
`default_nettype wire

// ### hdl/bsfr_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock; depth need not be a power of two
`timescale 1ns/100ps
`default_nettype none
module bsfr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  import bsfr_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [PW-1:0] wrPtrReg;
  logic [PW-1:0] rdPtrReg;
  logic [CW-1:0] countReg;
  logic [CW-1:0] countNext;
  logic readyReg;
  logic doPush;
  logic doPop;

  assign doPush = inValid && readyReg;
  assign doPop = outReady && (countReg != '0);
  assign outValid = (countReg != '0);
  assign outData = memReg[rdPtrReg];
  assign inReady = readyReg;

  always_comb
  begin
    countNext = countReg;
    if (doPush && !doPop)
    begin
      countNext = countReg + CW'(1);
    end
    else if (doPop && !doPush)
    begin
      countNext = countReg - CW'(1);
    end
  end

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++)
    begin : g_entry
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          memReg[e] <= '0;
        end
        else if (doPush && (wrPtrReg == PW'(e)))
        begin
          memReg[e] <= inData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
      readyReg <= 1'b0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtrReg <= (wrPtrReg == LAST_IDX) ? '0 : wrPtrReg + PW'(1);
      end
      if (doPop)
      begin
        rdPtrReg <= (rdPtrReg == LAST_IDX) ? '0 : rdPtrReg + PW'(1);
      end
      countReg <= countNext;
      // registered so the fill side never sees a combinational path from the drain
      readyReg <= (countNext != FULL_CNT);
    end
  end
endmodule : bsfr_fifo
`default_nettype wire

// ### hdl/bsfr_link_if.sv
// serial line between the network-side framer and the remote station
// assumes both ends run on the same clock, one line bit per clock
`timescale 1ns/100ps
`default_nettype none
interface bsfr_link_if;
  logic lineBit;
  modport device (output lineBit);
  modport station (input lineBit);
endinterface : bsfr_link_if
`default_nettype wire

// ### hdl/bsfr_pkg.sv
// shared constants and block check function of the framer pair
// assumes one clock shared by both ends and a bit-serial line
package bsfr_pkg;

  // control and framing characters
  localparam logic [7:0] CHAR_SYN = 8'h32;
  localparam logic [7:0] CHAR_DLE = 8'h10;
  localparam logic [7:0] CHAR_STX = 8'h02;
  localparam logic [7:0] CHAR_ETX = 8'h03;
  localparam logic [7:0] CHAR_PAD = 8'hFF;

  // address field values
  localparam logic [7:0] ADDR_NET_CMD = 8'h03;
  localparam logic [7:0] ADDR_NET_RSP = 8'h01;

  // control bit 1 (index 0) low marks an info frame
  localparam int CTRL_KIND_BIT = 0;

  // leading synchronizing characters
  localparam logic [1:0] TX_SYN_COUNT = 2'h3;
  localparam logic [1:0] RX_SYN_MIN = 2'h2;

  // block check generator, reflected form since bits go lsb first
  localparam logic [15:0] BCW_POLY_REV = 16'hA001;
  localparam logic [15:0] BCW_INIT = 16'h0000;

  // info byte buffer: one last-byte flag above eight data bits
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;

  // line level outside frames
  localparam logic LINE_IDLE = 1'b1;

  function automatic logic [15:0] bsfrCrcByte(input logic [15:0] crcIn, input logic [7:0] dataIn);
    logic [15:0] c;
    logic fb;
    c = crcIn;
    fb = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ dataIn[i];
      c = {1'b0, c[15:1]};
      if (fb)
      begin
        c = c ^ BCW_POLY_REV;
      end
    end
    return c;
  endfunction : bsfrCrcByte

endpackage : bsfr_pkg

// ### hdl/bsfr_station_end.sv
// remote station receiver: phase hunt and transparent parse
// assumes one line bit per clock
`timescale 1ns/100ps
`default_nettype none
module bsfr_station_end (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial line
  bsfr_link_if.station link,
  // delivered characters
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxFirst,
  // frame result
  output logic rxEnd,
  output logic rxCheckOk,
  output logic rxDrop,
  output logic [15:0] blockCheckWord
);
  import bsfr_pkg::*;

  typedef enum logic [2:0] {
    RX_HUNT, RX_SYNC, RX_SDLE, RX_BODY, RX_BDLE, RX_BCL, RX_BCH
  } bsfr_rx_state_t;

  bsfr_rx_state_t stateReg;
  logic [7:0] shReg;
  logic [7:0] shNext;
  logic [2:0] bitCntReg;
  logic [1:0] synCntReg;
  logic [15:0] crcReg;
  logic [7:0] bcwLoReg;
  logic firstReg;
  logic [7:0] dataReg;
  logic validReg;
  logic firstOutReg;
  logic endReg;
  logic okReg;
  logic dropReg;
  logic [15:0] bcwReg;
  logic charDone;

  assign shNext = {link.lineBit, shReg[7:1]};
  assign charDone = (stateReg != RX_HUNT) && (bitCntReg == 3'h7);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shReg <= 8'hFF;
      bitCntReg <= 3'h0;
    end
    else
    begin
      shReg <= shNext;
      bitCntReg <= (stateReg == RX_HUNT) ? 3'h0 : bitCntReg + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= RX_HUNT;
      synCntReg <= 2'h0;
      crcReg <= BCW_INIT;
      bcwLoReg <= 8'h00;
      firstReg <= 1'b0;
      dataReg <= 8'h00;
      validReg <= 1'b0;
      firstOutReg <= 1'b0;
      endReg <= 1'b0;
      okReg <= 1'b0;
      dropReg <= 1'b0;
      bcwReg <= 16'h0000;
    end
    else
    begin
      validReg <= 1'b0;
      endReg <= 1'b0;
      dropReg <= 1'b0;
      if (stateReg == RX_HUNT)
      begin
        // every line bit is a candidate phase
        if (shNext == CHAR_SYN)
        begin
          stateReg <= RX_SYNC;
          synCntReg <= 2'h1;
        end
      end
      else if (charDone)
      begin
        case (stateReg)
          RX_SYNC:
          begin
            if (shNext == CHAR_SYN)
            begin
              synCntReg <= (synCntReg == 2'h3) ? synCntReg : synCntReg + 2'h1;
            end
            else if (shNext == CHAR_DLE && synCntReg >= RX_SYN_MIN)
            begin
              stateReg <= RX_SDLE;
            end
            else
            begin
              stateReg <= RX_HUNT;
              dropReg <= 1'b1;
            end
          end
          RX_SDLE:
          begin
            if (shNext == CHAR_STX)
            begin
              stateReg <= RX_BODY;
              crcReg <= BCW_INIT;
              firstReg <= 1'b1;
            end
            else
            begin
              stateReg <= RX_HUNT;
              dropReg <= 1'b1;
            end
          end
          RX_BODY:
          begin
            if (shNext == CHAR_DLE)
            begin
              // next char decides data, end or fill
              stateReg <= RX_BDLE;
            end
            else
            begin
              dataReg <= shNext;
              validReg <= 1'b1;
              firstOutReg <= firstReg;
              firstReg <= 1'b0;
              crcReg <= bsfrCrcByte(crcReg, shNext);
            end
          end
          RX_BDLE:
          begin
            // pairs are consumed whole, so an ETX seen here follows an odd DLE run
            if (shNext == CHAR_DLE)
            begin
              stateReg <= RX_BODY;
              dataReg <= CHAR_DLE;
              validReg <= 1'b1;
              firstOutReg <= firstReg;
              firstReg <= 1'b0;
              crcReg <= bsfrCrcByte(crcReg, CHAR_DLE);
            end
            else if (shNext == CHAR_ETX)
            begin
              stateReg <= RX_BCL;
              crcReg <= bsfrCrcByte(crcReg, CHAR_ETX);
            end
            else if (shNext == CHAR_SYN)
            begin
              stateReg <= RX_BODY;
            end
            else
            begin
              stateReg <= RX_HUNT;
              dropReg <= 1'b1;
            end
          end
          RX_BCL:
          begin
            bcwLoReg <= shNext;
            stateReg <= RX_BCH;
          end
          RX_BCH:
          begin
            bcwReg <= {shNext, bcwLoReg};
            okReg <= ({shNext, bcwLoReg} == crcReg);
            endReg <= 1'b1;
            // pad is not checked: hunt resumes at once
            stateReg <= RX_HUNT;
          end
          default:
          begin
            stateReg <= RX_HUNT;
          end
        endcase
      end
    end
  end

  assign rxData = dataReg;
  assign rxValid = validReg;
  assign rxFirst = firstOutReg;
  assign rxEnd = endReg;
  assign rxCheckOk = okReg;
  assign rxDrop = dropReg;
  assign blockCheckWord = bcwReg;
endmodule : bsfr_station_end
`default_nettype wire

// ### verification/bisync_transparent_framer_tb_top.sv
// bench for the framer pair and a hand-driven second station
// assumes the package constants
`timescale 1ns/100ps
`default_nettype none
module bisync_transparent_framer_tb_top;
  import bsfr_pkg::*;
  logic clock, rst_n, frameStart, frameIsResponse, frameBusy, frameDone;
  logic [7:0] frameControl, infoData, rxData, rxData2, lineSh;
  logic infoLast, infoValid, infoReady, rxValid, rxFirst, rxEnd, rxCheckOk, rxDrop;
  logic rxValid2, rxEnd2, rxCheckOk2, rxDrop2;
  logic [15:0] frameLength, blockCheckWord, blockCheckWord2, expCrc;
  logic [7:0] lineQ[$], rxQ[$], rx2Q[$], expLine[$], expRx[$], dataQ[$];
  int num_errors, checked, bitCnt, firstCnt, endCnt, endCnt2, dropCnt2;

  bsfr_link_if linkMain();
  bsfr_link_if linkBad();
  bsfr_device_end bsfr_device_end_i (.clock(clock), .rst_n(rst_n), .frameStart(frameStart),
    .frameIsResponse(frameIsResponse), .frameControl(frameControl), .frameBusy(frameBusy),
    .frameDone(frameDone), .frameLength(frameLength), .infoData(infoData), .infoLast(infoLast),
    .infoValid(infoValid), .infoReady(infoReady), .link(linkMain));
  bsfr_station_end bsfr_station_end_i (.clock(clock), .rst_n(rst_n), .link(linkMain), .rxData(rxData),
    .rxValid(rxValid), .rxFirst(rxFirst), .rxEnd(rxEnd), .rxCheckOk(rxCheckOk), .rxDrop(rxDrop),
    .blockCheckWord(blockCheckWord));
  // bench-driven line, so far-side faults can be made
  bsfr_station_end bsfr_station_end_i_bad (.clock(clock), .rst_n(rst_n), .link(linkBad), .rxData(rxData2),
    .rxValid(rxValid2), .rxFirst(), .rxEnd(rxEnd2), .rxCheckOk(rxCheckOk2), .rxDrop(rxDrop2),
    .blockCheckWord(blockCheckWord2));
  bsfr_link_chk bsfr_link_chk_i (.clock(clock), .rst_n(rst_n), .lineBit(linkMain.lineBit),
    .frameStart(frameStart), .frameBusy(frameBusy), .frameDone(frameDone), .frameLength(frameLength),
    .rxEnd(rxEnd), .rxCheckOk(rxCheckOk), .rxDrop(rxDrop));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (rxValid) rxQ.push_back(rxData);
    if (rxValid && rxFirst) firstCnt++;
    if (rxEnd) endCnt++;
    if (rxValid2) rx2Q.push_back(rxData2);
    if (rxEnd2) endCnt2++;
    if (rxDrop2) dropCnt2++;
    bitCnt = frameBusy ? bitCnt + 1 : 0;
    lineSh = {linkMain.lineBit, lineSh[7:1]};
    if (frameBusy && bitCnt % 8 == 0) lineQ.push_back(lineSh);
  end

  function automatic logic [15:0] tbCrc(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb) c = c ^ 16'hA001;
    end
    return c;
  endfunction : tbCrc

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic cmpQ(input string what, input logic [7:0] seen[$], input logic [7:0] exp[$]);
    check({what, " count"}, 16'(seen.size()), 16'(exp.size()));
    foreach (exp[i])
      if (i < seen.size()) check(what, 16'(seen[i]), 16'(exp[i]));
  endtask : cmpQ

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic timedOut(input string what);
    $display("CHECK FAILED %s expected done seen timeout", what);
    num_errors++;
    wrap_up();
  endtask : timedOut

  task automatic push(input logic [7:0] b, input logic last);
    int n = 0;
    @(negedge clock);
    infoData = b;
    infoLast = last;
    infoValid = 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (infoReady !== 1'b1 && n < 300);
    if (n >= 300) timedOut("info push");
    @(negedge clock);
    infoValid = 1'b0;
  endtask : push

  task automatic startFrame(input logic resp, input logic [7:0] ctrl);
    @(negedge clock);
    frameStart = 1'b1;
    frameIsResponse = resp;
    frameControl = ctrl;
    @(negedge clock);
    frameStart = 1'b0;
  endtask : startFrame

  task automatic waitDone;
    int n = 0;
    @(negedge clock);
    while (frameDone !== 1'b1 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 5000) timedOut("frame");
  endtask : waitDone

  task automatic buildExp(input logic [7:0] addr, input logic [7:0] ctrl);
    expCrc = tbCrc(tbCrc(16'h0000, addr), ctrl);
    expLine = '{CHAR_SYN, CHAR_SYN, CHAR_SYN, CHAR_DLE, CHAR_STX, addr, ctrl};
    expRx = '{addr, ctrl};
    foreach (dataQ[i])
    begin
      expLine.push_back(dataQ[i]);
      if (dataQ[i] == CHAR_DLE) expLine.push_back(CHAR_DLE);
      expRx.push_back(dataQ[i]);
      expCrc = tbCrc(expCrc, dataQ[i]);
    end
    expCrc = tbCrc(expCrc, CHAR_ETX);
    expLine = {expLine, CHAR_DLE, CHAR_ETX, expCrc[7:0], expCrc[15:8], CHAR_PAD};
    lineQ.delete();
    rxQ.delete();
    firstCnt = 0;
    endCnt = 0;
  endtask : buildExp

  // fill makes line and length unpredictable
  task automatic finishFrame(input logic [15:0] len, input logic full);
    if (full) check("frame length", frameLength, len);
    if (full) cmpQ("line chars", lineQ, expLine);
    cmpQ("delivered chars", rxQ, expRx);
    check("first marks", 16'(firstCnt), 16'h0001);
    check("end pulses", 16'(endCnt), 16'h0001);
    check("check ok", 16'(rxCheckOk), 16'h0001);
    check("check word", blockCheckWord, expCrc);
  endtask : finishFrame

  task automatic testCmdInfo;
    dataQ = '{8'h10, 8'h55, 8'h10, 8'h03, 8'h32, 8'hA7};
    foreach (dataQ[i]) push(dataQ[i], i == 5);
    buildExp(ADDR_NET_CMD, 8'h00);
    startFrame(1'b0, 8'h00);
    waitDone();
    finishFrame(16'h0010, 1'b1);
    $display("command info done");
  endtask : testCmdInfo

  task automatic testSupResp;
    dataQ.delete();
    buildExp(ADDR_NET_RSP, 8'h01);
    startFrame(1'b1, 8'h01);
    waitDone();
    finishFrame(16'h0008, 1'b1);
    $display("sup response done");
  endtask : testSupResp

  task automatic testFill;
    dataQ.delete();
    for (int i = 0; i < FIFO_DEPTH; i++) dataQ.push_back(8'(i + 8));
    foreach (dataQ[i]) push(dataQ[i], i == FIFO_DEPTH - 1);
    @(posedge clock);
    @(negedge clock);
    check("ready when full", 16'(infoReady), 16'h0000);
    buildExp(ADDR_NET_CMD, 8'h22);
    startFrame(1'b0, 8'h22);
    waitDone();
    finishFrame(16'h0019, 1'b1);
    check("ready when drained", 16'(infoReady), 16'h0001);
    $display("fill done");
  endtask : testFill

  task automatic testUnderrun;
    dataQ = '{8'h10, 8'h41, 8'h7E};
    buildExp(ADDR_NET_CMD, 8'h00);
    startFrame(1'b0, 8'h00);
    foreach (dataQ[i])
    begin
      repeat (40) @(negedge clock);
      push(dataQ[i], i == 2);
    end
    waitDone();
    finishFrame(16'h0000, 1'b0);
    check("fill counted", 16'(frameLength > 16'h000C), 16'h0001);
    $display("underrun done");
  endtask : testUnderrun

  task automatic testBadLine;
    logic [7:0] chars[$];
    logic [15:0] crc;
    crc = tbCrc(tbCrc(tbCrc(tbCrc(tbCrc(16'h0000, 8'h03), 8'h00), 8'h10), 8'h41), CHAR_ETX);
    // two syncs, a doubled DLE, a time-fill pair
    chars = '{CHAR_SYN, CHAR_SYN, CHAR_DLE, CHAR_STX, 8'h03, 8'h00, CHAR_DLE, CHAR_DLE, 8'h41,
      CHAR_DLE, CHAR_SYN, CHAR_DLE, CHAR_ETX, crc[7:0], crc[15:8], CHAR_PAD};
    foreach (chars[i]) sendChar(chars[i]);
    repeat (16) @(negedge clock);
    cmpQ("far chars", rx2Q, '{8'h03, 8'h00, 8'h10, 8'h41});
    check("far end pulses", 16'(endCnt2), 16'h0001);
    check("far check ok", 16'(rxCheckOk2), 16'h0001);
    check("far check word", blockCheckWord2, crc);
    chars = '{CHAR_SYN, CHAR_SYN, CHAR_SYN, CHAR_DLE, 8'h41, CHAR_PAD};
    foreach (chars[i]) sendChar(chars[i]);
    repeat (16) @(negedge clock);
    check("far phase drop", 16'(dropCnt2 > 0), 16'h0001);
    $display("far faults done");
  endtask : testBadLine

  task automatic sendChar(input logic [7:0] c);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clock);
      linkBad.lineBit = c[i];
    end
  endtask : sendChar

  initial
  begin
    rst_n = 1'b0;
    frameStart = 1'b0;
    frameIsResponse = 1'b0;
    frameControl = 8'h00;
    infoData = 8'h00;
    infoLast = 1'b0;
    infoValid = 1'b0;
    linkBad.lineBit = LINE_IDLE;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    testCmdInfo();
    testSupResp();
    testFill();
    testUnderrun();
    testBadLine();
    wrap_up();
  end
endmodule : bisync_transparent_framer_tb_top
`default_nettype wire

// ### verification/bsfr_link_chk.sv
// assertions on the main line and both ends' status
// assumes one clock and one line bit per clock
`timescale 1ns/100ps
`default_nettype none
module bsfr_link_chk
  import bsfr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // line and device status
  input wire logic lineBit,
  input wire logic frameStart,
  input wire logic frameBusy,
  input wire logic frameDone,
  input wire logic [15:0] frameLength,
  // station status
  input wire logic rxEnd,
  input wire logic rxCheckOk,
  input wire logic rxDrop
);
  logic [7:0] lineShReg;
  logic [15:0] busyCntReg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lineShReg <= 8'hFF;
    else
      lineShReg <= {lineBit, lineShReg[7:1]};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busyCntReg <= 16'h0000;
    else
      busyCntReg <= frameBusy ? busyCntReg + 16'h0001 : 16'h0000;
  end

  sequence s_frame_close;
    $fell(frameBusy) ##0 frameDone;
  endsequence
  sequence s_done_soon;
    ##[6:9] frameDone;
  endsequence

  property p_three_syn;
    frameBusy && busyCntReg inside {16'h0008, 16'h0010, 16'h0018} |-> lineShReg == CHAR_SYN;
  endproperty
  a_three_syn: assert property (p_three_syn) else $error("sync char");
  property p_start_dle;
    frameBusy && busyCntReg == 16'h0020 |-> lineShReg == CHAR_DLE;
  endproperty
  a_start_dle: assert property (p_start_dle) else $error("start DLE");
  property p_start_stx;
    frameBusy && busyCntReg == 16'h0028 |-> lineShReg == CHAR_STX;
  endproperty
  a_start_stx: assert property (p_start_stx) else $error("start STX");
  property p_idle_high;
    !frameBusy |-> lineBit == LINE_IDLE;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle");
  property p_pad_last;
    $fell(frameBusy) |-> lineShReg == CHAR_PAD;
  endproperty
  a_pad_last: assert property (p_pad_last) else $error("pad char");
  property p_length;
    s_frame_close |-> busyCntReg == ((frameLength + 16'h0004) << 3);
  endproperty
  a_length: assert property (p_length) else $error("frame length");
  property p_done_pulse;
    $fell(frameBusy) |-> frameDone ##1 !frameDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse");
  property p_start_taken;
    frameStart && !frameBusy |=> frameBusy;
  endproperty
  a_start_taken: assert property (p_start_taken) else $error("idle start not taken");
  property p_rx_end_time;
    rxEnd |-> s_done_soon;
  endproperty
  a_rx_end_time: assert property (p_rx_end_time) else $error("check end timing");
  property p_check_ok;
    rxEnd |-> rxCheckOk;
  endproperty
  a_check_ok: assert property (p_check_ok) else $error("block check bad");
  property p_no_drop;
    frameBusy |-> !rxDrop;
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("phase dropped");
endmodule : bsfr_link_chk
`default_nettype wire
